// file: shared/flash_cmd_map.svh
// constants for the flash command decoder and write sequencer
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
`define ID_MAKER_OFFSET     24'h00_0000
`define ID_PART_OFFSET      24'h00_0001
`define ERASED_BYTE         8'hFF
`define BIT_READY           7
`define BIT_ERASE_SUSP      6
`define BIT_ERASE_ERR       5
`define BIT_PROG_ERR        4
`define BIT_SUPPLY_LOW      3
`define BIT_PROG_SUSP       2
`define BIT_PROTECT_ABORT   1
`define STATUS_RESET        8'h80
`define ERASE_STEPS_DEFAULT 16
`define PROG_STEPS_DEFAULT  4
`define SUSPEND_POINT       2'h3
`endif

// file: shared/flash_cmd_pkg.sv
// types for the flash command decoder and write sequencer
package flash_cmd_pkg;
  typedef enum logic [1:0] {
    mode_array,
    mode_ident,
    mode_status
  } read_mode_t;

  typedef enum logic [2:0] {
    seq_idle,
    seq_erase,
    seq_erase_susp,
    seq_prog,
    seq_prog_susp,
    seq_prog_in_esusp
  } seq_state_t;
endpackage : flash_cmd_pkg

// file: logic/flash_command_state_machine.sv
// command decoder and write sequencer for a byte-wide flash
`include "flash_cmd_map.svh"

module flash_command_state_machine
  import flash_cmd_pkg::*;
#(
  parameter int          ADDR_W      = 24,
  parameter int          BLOCK_W     = 16,
  parameter int          ERASE_STEPS = `ERASE_STEPS_DEFAULT,
  parameter int          PROG_STEPS  = `PROG_STEPS_DEFAULT,
  parameter logic [7:0]  MAKER_ID    = 8'h5A, // arbitrary value
  parameter logic [7:0]  PART_ID     = 8'hA5, // arbitrary value
  parameter logic [7:0]  OP_READ     = 8'h01,
  parameter logic [7:0]  OP_IDENT    = 8'h02,
  parameter logic [7:0]  OP_STATUS   = 8'h03,
  parameter logic [7:0]  OP_CLEAR    = 8'h04,
  parameter logic [7:0]  OP_ERASE    = 8'h05,
  parameter logic [7:0]  OP_CONFIRM  = 8'h06,
  parameter logic [7:0]  OP_PROGRAM  = 8'h07,
  parameter logic [7:0]  OP_SUSPEND  = 8'h08,
  parameter logic [7:0]  OP_RESUME   = 8'h09
)(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // host bus, one-cycle strobes
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  output logic      [7:0]        rdata_q,
  output logic                   rvalid_q,
  // protection and supply
  input  wire logic              block_locked,
  input  wire logic              top_block_protect_n,
  input  wire logic              write_protect_n,
  input  wire logic              program_supply_ok,
  // array port
  input  wire logic [7:0]        array_rdata,
  output logic                   array_we_q,
  output logic                   array_erase_q,
  output logic [ADDR_W-1:0]      array_addr_q,
  output logic [7:0]             array_wdata_q,
  // status view
  output logic [7:0]             status_q
);

  localparam int BLK_LSB = ADDR_W - BLOCK_W;

  read_mode_t        mode_q;
  seq_state_t        seq_q;
  logic              await_erase_q;
  logic              await_prog_q;
  logic [15:0]       erase_cnt_q;
  logic [15:0]       prog_cnt_q;
  logic [ADDR_W-1:0] erase_addr_q;
  logic [ADDR_W-1:0] prog_addr_q;
  logic [7:0]        prog_data_q;
  logic              verify_q;
  logic              rd_q;
  logic              erase_err_set;
  logic              prog_err_set;
  logic              supply_set;
  logic              protect_set;
  logic              seq_done;

  // protect pin covers only the top block, the other pin the rest
  function automatic logic protected_at(input logic [ADDR_W-1:0] a);
    logic top;
    top = &a[ADDR_W-1:BLK_LSB];
    protected_at = block_locked
                 | (top ? ~top_block_protect_n : ~write_protect_n);
  endfunction : protected_at

  function automatic logic same_block(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] b);
    same_block = a[ADDR_W-1:BLK_LSB] == b[ADDR_W-1:BLK_LSB];
  endfunction : same_block

  logic known_op;
  logic busy;
  logic in_esusp;
  logic in_psusp;
  logic cmd_ok;
  assign known_op = wdata inside {OP_READ, OP_IDENT, OP_STATUS,
                                  OP_CLEAR, OP_ERASE, OP_CONFIRM,
                                  OP_PROGRAM, OP_SUSPEND, OP_RESUME};
  assign busy     = seq_q inside {seq_erase, seq_prog, seq_prog_in_esusp}
                    || array_we_q || array_erase_q || verify_q;
  assign in_esusp = seq_q == seq_erase_susp;
  assign in_psusp = seq_q == seq_prog_susp;

  // what a plain command write may do in the present sequencer state
  always_comb
  begin
    cmd_ok = 1'b1;
    if (await_erase_q || await_prog_q)
      cmd_ok = 1'b1;
    else if (in_esusp)
      cmd_ok = wdata inside {OP_READ, OP_PROGRAM, OP_STATUS, OP_RESUME};
    else if (in_psusp)
      cmd_ok = wdata inside {OP_READ, OP_STATUS, OP_RESUME};
    else if (busy)
      cmd_ok = wdata inside {OP_STATUS, OP_SUSPEND};
  end

  logic take;
  logic erase_susp_take;
  logic prog_susp_take;
  assign take = wr_en && cmd_ok;
  // suspend lands only on the fixed step boundary
  assign erase_susp_take = seq_q == seq_erase && take && wdata == OP_SUSPEND
                           && erase_cnt_q[1:0] == `SUSPEND_POINT;
  assign prog_susp_take  = seq_q == seq_prog && take && wdata == OP_SUSPEND
                           && prog_cnt_q[1:0] == `SUSPEND_POINT;

  // read mode follows the last accepted command; clear, a lone confirm or an unknown byte keeps it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_q <= mode_array;
    else if (take && !await_erase_q && !await_prog_q)
    begin
      case (wdata)
        OP_READ:    mode_q <= mode_array;
        OP_IDENT:   mode_q <= mode_ident;
        OP_STATUS:  mode_q <= mode_status;
        OP_ERASE,
        OP_PROGRAM,
        OP_SUSPEND,
        OP_RESUME:  mode_q <= mode_status;
        default:    mode_q <= mode_q;
      endcase
    end
    else if (take)
      mode_q <= mode_status;
  end

  // two-write setup: erase then confirm, program then data
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      await_erase_q <= 1'b0;
      await_prog_q  <= 1'b0;
    end
    else if (take)
    begin
      await_erase_q <= !await_erase_q && !await_prog_q
                       && wdata == OP_ERASE && seq_q == seq_idle;
      await_prog_q  <= !await_erase_q && !await_prog_q
                       && wdata == OP_PROGRAM
                       && (seq_q == seq_idle || in_esusp);
    end
  end

  // write sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      seq_q        <= seq_idle;
      erase_cnt_q  <= '0;
      prog_cnt_q   <= '0;
      erase_addr_q <= '0;
      prog_addr_q  <= '0;
      prog_data_q  <= 8'h00;
    end
    else
    begin
      case (seq_q)
        seq_idle:
          if (take && await_erase_q && wdata == OP_CONFIRM
              && program_supply_ok && !protected_at(addr))
          begin
            seq_q        <= seq_erase;
            erase_addr_q <= addr;
            erase_cnt_q  <= '0;
          end
          else if (take && await_prog_q
                   && program_supply_ok && !protected_at(addr))
          begin
            seq_q       <= seq_prog;
            prog_addr_q <= addr;
            prog_data_q <= wdata;
            prog_cnt_q  <= '0;
          end
        seq_erase:
          if (erase_susp_take)
            seq_q <= seq_erase_susp;
          else if (erase_cnt_q == 16'(ERASE_STEPS - 1))
            seq_q <= seq_idle;
          else
            erase_cnt_q <= erase_cnt_q + 16'h0001;
        seq_erase_susp:
          if (take && !await_prog_q && wdata == OP_RESUME)
            seq_q <= seq_erase;
          else if (take && await_prog_q && program_supply_ok
                   && !protected_at(addr)
                   && !same_block(addr, erase_addr_q))
          begin
            seq_q       <= seq_prog_in_esusp;
            prog_addr_q <= addr;
            prog_data_q <= wdata;
            prog_cnt_q  <= '0;
          end
        seq_prog,
        seq_prog_in_esusp:
          if (prog_susp_take)
            seq_q <= seq_prog_susp;
          else if (prog_cnt_q == 16'(PROG_STEPS - 1))
            seq_q <= (seq_q == seq_prog) ? seq_idle
                                         : seq_erase_susp;
          else
            prog_cnt_q <= prog_cnt_q + 16'h0001;
        seq_prog_susp:
          if (take && wdata == OP_RESUME)
            seq_q <= seq_prog;
        default:
          seq_q <= seq_idle;
      endcase
    end
  end

  // abort causes and completion checks
  logic erase_start;
  logic prog_start;
  assign erase_start = take && await_erase_q;
  assign prog_start  = take && await_prog_q;
  assign supply_set  = (erase_start && wdata == OP_CONFIRM || prog_start)
                       && !program_supply_ok;
  assign protect_set = (erase_start && wdata == OP_CONFIRM
                        || prog_start) && protected_at(addr);
  assign seq_done    = (seq_q == seq_prog || seq_q == seq_prog_in_esusp)
                       && prog_cnt_q == 16'(PROG_STEPS - 1)
                       && !prog_susp_take;
  // bad confirm or unknown byte counts as a bad sequence
  logic bad_seq;
  assign bad_seq = wr_en && (!known_op && !await_prog_q
                   || erase_start && wdata != OP_CONFIRM);
  // only bits asked to fall that stayed high are caught
  assign prog_err_set  = bad_seq
                         || (supply_set || protect_set) && prog_start
                         || verify_q
                            && |(~array_wdata_q & array_rdata);
  assign erase_err_set = bad_seq || (supply_set || protect_set)
                         && erase_start;

  // the cell is read back the cycle after its write pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      verify_q <= 1'b0;
    else
      verify_q <= array_we_q;
  end

  // sticky error bits: a set in the clearing cycle wins
  logic [7:0] err_q;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      err_q <= 8'h00;
    else
    begin
      if (take && !await_erase_q && !await_prog_q && wdata == OP_CLEAR)
        err_q <= 8'h00;
      if (erase_err_set)
        err_q[`BIT_ERASE_ERR] <= 1'b1;
      if (prog_err_set)
        err_q[`BIT_PROG_ERR] <= 1'b1;
      if (supply_set)
        err_q[`BIT_SUPPLY_LOW] <= 1'b1;
      if (protect_set)
        err_q[`BIT_PROTECT_ABORT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_q <= `STATUS_RESET;
    else
    begin
      status_q <= err_q;
      status_q[`BIT_READY]      <= !busy;
      status_q[`BIT_ERASE_SUSP] <= in_esusp
                                   || seq_q == seq_prog_in_esusp;
      status_q[`BIT_PROG_SUSP]  <= in_psusp;
      status_q[0]               <= 1'b0;
    end
  end

  // array drive: erase pulses once at the last step, program writes at the end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      array_we_q    <= 1'b0;
      array_erase_q <= 1'b0;
      array_addr_q  <= '0;
      array_wdata_q <= 8'h00;
    end
    else
    begin
      array_erase_q <= seq_q == seq_erase && !erase_susp_take
                       && erase_cnt_q == 16'(ERASE_STEPS - 1);
      array_we_q    <= seq_done;
      array_wdata_q <= array_erase_q ? `ERASED_BYTE : prog_data_q;
      if (seq_q == seq_erase)
        array_addr_q <= erase_addr_q;
      else if (seq_done)
        array_addr_q <= prog_addr_q;
      else if (rd_en && !array_we_q && !array_erase_q)
        array_addr_q <= addr; // held through the pulse for verify
    end
  end

  // array address is registered, so data answers two edges after strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rd_q     <= 1'b0;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rd_q     <= rd_en;
      rvalid_q <= rd_q;
      if (rd_q)
      begin
        case (mode_q)
          mode_array:  rdata_q <= array_rdata;
          mode_ident:  rdata_q <= (array_addr_q == `ID_PART_OFFSET)
                                  ? PART_ID
                                  : (array_addr_q == `ID_MAKER_OFFSET)
                                  ? MAKER_ID : 8'h00;
          mode_status: rdata_q <= status_q;
          default:     rdata_q <= 8'h00;
        endcase
      end
    end
  end

endmodule : flash_command_state_machine

// file: verif/flash_cmd_properties.sv
// port assertions for the flash command block
module flash_cmd_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // host bus
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic       rvalid_q,
  // array port and status
  input wire logic       array_we_q,
  input wire logic       array_erase_q,
  input wire logic [7:0] status_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (rd_en |-> ##2 rvalid_q)
    else $error("read strobe not answered");
  a_valid_cause: assert property (rvalid_q |-> $past(rd_en, 2))
    else $error("read valid without strobe");
  a_reset_status: assert property ($past(rst) |-> status_q == 8'h80)
    else $error("status not ready after reset");
  a_we_pulse: assert property (array_we_q |=> !array_we_q)
    else $error("program pulse too long");
  a_erase_pulse: assert property (array_erase_q |=> !array_erase_q)
    else $error("erase pulse too long");
  a_port_excl: assert property (!(array_we_q && array_erase_q))
    else $error("program and erase together");
  a_we_busy: assert property (array_we_q |-> !status_q[7])
    else $error("array write while ready");
  // error flags may only gain ones without a host write
  a_error_hold: assert property (!wr_en && !$past(wr_en) |=>
    ((status_q & $past(status_q)) & 8'h3A) == ($past(status_q) & 8'h3A))
    else $error("error flag dropped without clear");
  a_ready_hold: assert property (status_q[7] && !wr_en && !$past(wr_en)
    |=> status_q[7])
    else $error("busy without a command");
endmodule : flash_cmd_properties

// file: verif/flash_array_model.sv
// array memory model behind the flash block, two blocks deep
module flash_array_model (
  // clock
  input wire logic        clk,
  // array port
  input wire logic        array_we_q,
  input wire logic        array_erase_q,
  input wire logic [23:0] array_addr_q,
  input wire logic [7:0]  array_wdata_q,
  output logic     [7:0]  array_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [512];
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // programming only clears bits, as real cells do
  always @(posedge clk)
  begin
    if (array_erase_q)
      for (int i = 0; i < 256; i++)
        mem[{array_addr_q[8], i[7:0]}] <= 8'hFF;
    if (array_we_q)
      mem[array_addr_q[8:0]] <= mem[array_addr_q[8:0]] & array_wdata_q;
  end
  assign array_rdata = mem[array_addr_q[8:0]];
endmodule : flash_array_model

// file: verif/flash_command_state_machine_tb_top.sv
// self-checking bench for the flash command block
module flash_command_state_machine_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, lock = 0, tbp_n = 1;
  logic wp_n = 1, sup_ok = 1, we, er;
  logic [23:0] addr = '0, aaddr;
  logic [7:0]  wdata = '0, rdata_q, ard, awd, status_q;
  logic        rvalid_q;
  int miscompares = 0, cmp_count = 0;
  always #25 clk = ~clk;
  flash_command_state_machine u_dut (.clk(clk), .rst(rst), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .block_locked(lock), .top_block_protect_n(tbp_n),
    .write_protect_n(wp_n), .program_supply_ok(sup_ok), .array_rdata(ard),
    .array_we_q(we), .array_erase_q(er), .array_addr_q(aaddr),
    .array_wdata_q(awd), .status_q(status_q));
  flash_array_model u_mem (.clk(clk), .array_we_q(we), .array_erase_q(er),
    .array_addr_q(aaddr), .array_wdata_q(awd), .array_rdata(ard));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    @(posedge clk); #5;
    wr_en = 1; addr = a; wdata = d;
    @(posedge clk); #5;
    wr_en = 0;
  endtask : wr
  // read data stands two edges after the strobe is taken
  task automatic rd(input logic [23:0] a);
    @(posedge clk); #5;
    rd_en = 1; addr = a;
    @(posedge clk); #5;
    rd_en = 0;
    @(posedge clk); #5;
  endtask : rd
  task automatic prog(input logic [23:0] a, input logic [7:0] d);
    wr(a, u_dut.OP_PROGRAM);
    wr(a, d);
  endtask : prog
  task automatic erase(input logic [23:0] a);
    wr(a, u_dut.OP_ERASE);
    wr(a, u_dut.OP_CONFIRM);
  endtask : erase
  // busy shows in status only a few cycles after the last write
  task automatic wait_ready();
    repeat (3) @(posedge clk);
    for (int n = 0; n < 100; n++)
    begin
      rd(24'h00_0000);
      if (rdata_q[7] === 1'b1) return;
    end
    miscompares++;
    $display("mismatch at %0t: sequencer stuck busy", $time);
    end_sim();
  endtask : wait_ready
  task automatic clear_err();
    wr(0, u_dut.OP_CLEAR);
    wr(0, u_dut.OP_STATUS);
    rd(0);
    chk(rdata_q, 8'h80);
  endtask : clear_err
  task automatic read_modes();
    rd(24'h00_0005);
    chk(rdata_q, 8'hFF);
    wr(0, u_dut.OP_IDENT);
    rd(24'h00_0000);
    chk(rdata_q, u_dut.MAKER_ID);
    rd(24'h00_0001);
    chk(rdata_q, u_dut.PART_ID);
    rd(24'h00_0000);
    chk(rdata_q, u_dut.MAKER_ID);
  endtask : read_modes
  task automatic program_erase();
    prog(24'h00_0005, 8'h3C);
    wait_ready();
    chk(rdata_q, 8'h80);
    prog(24'h00_0005, 8'hFF);
    wait_ready();
    chk(rdata_q, 8'h80);
    prog(24'h00_0105, 8'h3C);
    wr(0, u_dut.OP_READ);
    wait_ready();
    chk(rdata_q, 8'h80);
    erase(24'h00_01F0);
    wait_ready();
    chk(rdata_q, 8'h80);
    wr(0, u_dut.OP_READ);
    rd(24'h00_0105);
    chk(rdata_q, 8'hFF);
    rd(24'h00_0005);
    chk(rdata_q, 8'h3C);
  endtask : program_erase
  // three-cycle spacing meets every phase of the suspend point
  task automatic suspend_resume();
    erase(24'h00_01F0);
    repeat (5)
    begin
      wr(0, u_dut.OP_SUSPEND); // rst stays released throughout
      @(posedge clk);
    end
    rd(0);
    chk(rdata_q, 8'hC0);
    wr(0, u_dut.OP_READ);
    rd(24'h00_0005);
    chk(rdata_q, 8'h3C);
    wr(0, u_dut.OP_RESUME);
    wr(0, u_dut.OP_STATUS);
    wait_ready();
    chk(rdata_q, 8'h80);
    prog(24'h00_0006, 8'h0F);
    // suspend must land on the last program step
    repeat (2) @(posedge clk);
    wr(0, u_dut.OP_SUSPEND);
    rd(0);
    chk(rdata_q, 8'h84);
    wr(0, u_dut.OP_READ);
    rd(24'h00_0005);
    chk(rdata_q, 8'h3C);
    wr(0, u_dut.OP_RESUME);
    wait_ready();
    chk(rdata_q, 8'h80);
    wr(0, u_dut.OP_READ);
    rd(24'h00_0006);
    chk(rdata_q, 8'h0F);
  endtask : suspend_resume
  task automatic failures();
    lock = 1;
    prog(24'h00_0007, 8'h00);
    wait_ready();
    chk(rdata_q, 8'h92);
    lock = 0;
    rd(0);
    chk(rdata_q, 8'h92);
    clear_err();
    wp_n = 0;
    erase(24'h00_0100);
    wait_ready();
    chk(rdata_q, 8'hA2);
    wp_n = 1;
    clear_err();
    wr(0, u_dut.OP_ERASE);
    wr(0, u_dut.OP_READ);
    wr(0, u_dut.OP_STATUS);
    rd(0);
    chk(rdata_q, 8'hB0);
    clear_err();
  endtask : failures
  initial
  begin
    repeat (3) @(posedge clk);
    #5;
    rst = 0;
    read_modes();
    program_erase();
    suspend_resume();
    failures();
    end_sim();
  end
endmodule : flash_command_state_machine_tb_top

bind flash_command_state_machine flash_cmd_properties u_props (.clk(clk),
  .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .rvalid_q(rvalid_q),
  .array_we_q(array_we_q), .array_erase_q(array_erase_q),
  .status_q(status_q));
